// file: src/scan_trigger_controller.sv
// Reading-request controller for single-read acquisitions in slave mode.
// Overview of operation
// - A read request comes from the button, a start command, or external input.
// - Single read starts on request, outputs one result on success or timeout.
// - Edge mode starts acquisition only on an off-to-on request transition.
// - Any finite reading timeout selects edge-activated triggering.
// - Edge external request stops on successful read or timeout expiry.
// - Level mode keeps acquiring while the request stays on.
// - An infinite reading timeout selects level-activated triggering.
// - Level external request stops on successful read or external input off.
// - Linked control lights orange at start, off at illumination end or stop.
// - Linked control lights green or red at stop, off at illumination or start.
// - Linked control judges success or verification match when acquisition stops.
// - Entering slave mode turns all status indicators off.
// - Slave mode entered at power-up without button, or by the mode button or a command.
// - Mode changes come from the button or from communication commands.
// - A mode change without save reverts uncommitted settings.
// - Four operating modes exist: slave, setup, maintenance and master.
// - A failed read returns a single question-mark character.
`timescale 1ns/10ps
module scan_trigger_controller
  import scan_trigger_pkg::*;
#(
  parameter int ILLUM_TIME_CYCLES = ILLUM_CYCLES,
  parameter int BUTTON_TIME_CYCLES = BUTTON_TIMEOUT_CYCLES,
  parameter int TICKS_PER_MS = CYCLES_PER_MS
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Request sources.
  input wire logic button,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic ext_input,
  input wire logic ext_is_start,
  // Mode commands.
  input wire logic cmd_mode_valid,
  input wire op_mode_t cmd_mode,
  input wire logic button_mode,
  input wire logic cmd_save,
  // Configuration.
  input wire logic [TIMEOUT_W-1:0] timeout_ms,
  input wire logic linked_ctrl,
  input wire logic verify_en,
  // Decoder results.
  input wire logic decode_ok,
  input wire logic verify_match,
  // Acquisition and result outputs.
  output logic acquiring,
  output logic result_valid,
  output logic result_good,
  output logic result_fail_char_valid,
  output logic [7:0] result_char,
  // Status indicators.
  output logic led_orange,
  output logic led_green,
  output logic led_red,
  // Mode and settings status.
  output op_mode_t mode,
  output logic settings_revert
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ
  } acq_state_t;

  typedef struct packed {
    acq_state_t state;
    req_src_t src;
    logic level_mode;
    logic [CNT_W-1:0] tmo_cnt;
    logic [CNT_W-1:0] tmo_limit;
    logic [CNT_W-1:0] illum_cnt;
    logic acquiring;
    logic result_valid;
    logic result_good;
    logic result_fail_char_valid;
    logic [7:0] result_char;
    logic led_orange;
    logic led_green;
    logic led_red;
    op_mode_t mode;
    logic powered;
    logic dirty;
    logic settings_revert;
    logic [TIMEOUT_W-1:0] cfg_shadow;
  } state_t;

  state_t cur;
  state_t next_cur;
  logic [2:0] rise;
  logic [2:0] levels;

  // Request levels: button, command start, and external input when assigned.
  assign levels = {ext_input & ext_is_start, cmd_start, button};

  scan_edge_detect #(.WIDTH(3)) u_edge (
    .clk(clk),
    .reset(reset),
    .level(levels),
    .rise(rise)
  );

  // Timeout in cycles for a finite setting; the button uses its own fixed time.
  function automatic logic [CNT_W-1:0] limit_of(input logic [TIMEOUT_W-1:0] ms,
                                               input logic is_button);
    logic [CNT_W-1:0] v;
    v = is_button ? CNT_W'(BUTTON_TIME_CYCLES) : CNT_W'(ms) * CNT_W'(TICKS_PER_MS);
    return v;
  endfunction : limit_of

  // Next-state logic for acquisition, indicators and mode handling.
  always_comb begin
    logic start;
    logic stop;
    logic infinite;
    req_src_t new_src;
    start = 1'b0;
    stop = 1'b0;
    new_src = SRC_NONE;
    next_cur = cur;
    next_cur.result_valid = 1'b0;
    next_cur.result_fail_char_valid = 1'b0;
    next_cur.settings_revert = 1'b0;
    infinite = (timeout_ms == TIMEOUT_INFINITE);
    // Power-up: slave mode unless the button is held.
    if (!cur.powered) begin
      next_cur.powered = 1'b1;
      next_cur.mode = button ? MODE_SETUP : MODE_SLAVE;
      next_cur.cfg_shadow = timeout_ms;
    end
    // Starting conditions; the button offers no level activation.
    // Every source starts on its rising edge, so one request gives one read in level mode too.
    // A mode change arriving in the same cycle takes precedence over a new start.
    if (cur.mode == MODE_SLAVE && cur.state == ST_IDLE && cur.powered
        && !(cmd_mode_valid || button_mode)) begin
      if (rise[0] && !infinite) begin
        new_src = SRC_BUTTON;
      end else if (infinite ? cmd_start && rise[1] : rise[1]) begin
        new_src = SRC_COMMAND;
      end else if (rise[2]) begin
        new_src = SRC_EXTERNAL;
      end
      start = (new_src != SRC_NONE);
    end
    // Stop conditions while acquiring.
    if (cur.state == ST_ACQ) begin
      if (decode_ok) begin
        stop = 1'b1;
      end else if (!cur.level_mode && cur.tmo_cnt + 1 >= cur.tmo_limit) begin
        stop = 1'b1;
      end else if (cur.level_mode && cur.src == SRC_EXTERNAL && !levels[2]) begin
        stop = 1'b1;
      end else if (cur.src == SRC_COMMAND && cmd_stop) begin
        stop = 1'b1;
      end else begin
        next_cur.tmo_cnt = cur.tmo_cnt + 1;
      end
    end
    if (start) begin
      next_cur.state = ST_ACQ;
      next_cur.src = new_src;
      next_cur.level_mode = infinite;
      next_cur.tmo_cnt = '0;
      next_cur.tmo_limit = limit_of(timeout_ms, new_src == SRC_BUTTON);
      next_cur.acquiring = 1'b1;
      if (linked_ctrl) begin
        next_cur.led_orange = 1'b1;
        next_cur.led_green = 1'b0;
        next_cur.led_red = 1'b0;
        next_cur.illum_cnt = '0;
      end
    end else if (stop) begin
      next_cur.state = ST_IDLE;
      next_cur.src = SRC_NONE;
      next_cur.tmo_cnt = '0;
      next_cur.acquiring = 1'b0;
      next_cur.result_valid = 1'b1;
      next_cur.result_good = verify_en ? decode_ok && verify_match : decode_ok;
      next_cur.result_fail_char_valid = !decode_ok;
      next_cur.result_char = FAIL_CHAR;
      if (linked_ctrl) begin
        next_cur.led_orange = 1'b0;
        next_cur.led_green = next_cur.result_good;
        next_cur.led_red = !next_cur.result_good;
        next_cur.illum_cnt = '0;
      end
    end else if (cur.led_orange || cur.led_green || cur.led_red) begin
      // Illumination period expiry extinguishes whatever is lit.
      if (cur.illum_cnt + 1 >= CNT_W'(ILLUM_TIME_CYCLES)) begin
        next_cur.led_orange = 1'b0;
        next_cur.led_green = 1'b0;
        next_cur.led_red = 1'b0;
        next_cur.illum_cnt = '0;
      end else begin
        next_cur.illum_cnt = cur.illum_cnt + 1;
      end
    end
    // Settings tracking: a changed timeout is uncommitted until saved.
    if (cmd_save) begin
      next_cur.cfg_shadow = timeout_ms;
      next_cur.dirty = 1'b0;
    end else if (cur.powered && timeout_ms != cur.cfg_shadow) begin
      next_cur.dirty = 1'b1;
    end
    // Mode changes from the button or from commands.
    if (cur.powered && (cmd_mode_valid || button_mode) && cur.state == ST_IDLE) begin
      next_cur.mode = cmd_mode_valid ? cmd_mode : MODE_SLAVE;
      next_cur.settings_revert = next_cur.dirty;
      next_cur.dirty = 1'b0;
      if (next_cur.mode == MODE_SLAVE) begin
        next_cur.led_orange = 1'b0;
        next_cur.led_green = 1'b0;
        next_cur.led_red = 1'b0;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register.
  assign acquiring = cur.acquiring;
  assign result_valid = cur.result_valid;
  assign result_good = cur.result_good;
  assign result_fail_char_valid = cur.result_fail_char_valid;
  assign result_char = cur.result_char;
  assign led_orange = cur.led_orange;
  assign led_green = cur.led_green;
  assign led_red = cur.led_red;
  assign mode = cur.mode;
  assign settings_revert = cur.settings_revert;

endmodule : scan_trigger_controller

// file: inc/scan_trigger_pkg.sv
// Package with modes, request sources, timing and character constants for the scan trigger controller.
package scan_trigger_pkg;

  // Operating modes of the scanner.
  typedef enum logic [1:0] {
    MODE_SLAVE,
    MODE_SETUP,
    MODE_MAINT,
    MODE_MASTER
  } op_mode_t;

  // Request source that started the current acquisition.
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_BUTTON,
    SRC_COMMAND,
    SRC_EXTERNAL
  } req_src_t;

  // Clock rate and timing figures.
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  localparam int BUTTON_TIMEOUT_MS = 5000;
  localparam int BUTTON_TIMEOUT_CYCLES = BUTTON_TIMEOUT_MS * CYCLES_PER_MS;
  localparam int ILLUM_MS = 1000;
  localparam int ILLUM_CYCLES = ILLUM_MS * CYCLES_PER_MS;

  // Width of the millisecond timeout setting; zero means infinite.
  localparam int TIMEOUT_W = 15;
  localparam logic [TIMEOUT_W-1:0] TIMEOUT_INFINITE = 15'h0000;

  // Width of the cycle counters.
  localparam int CNT_W = 32;

  // Result character returned for a failed read.
  localparam logic [7:0] FAIL_CHAR = 8'h3F;

endpackage : scan_trigger_pkg

// file: src/scan_edge_detect.sv
// Rising edge detector for the three request sources.
`timescale 1ns/10ps
module scan_edge_detect #(
  parameter int WIDTH = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Levels in and one-cycle rising pulses out.
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] last;

  // Remember the previous level of each input.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last <= '0;
    end else begin
      last <= level;
    end
  end

  // Each bit rises independently.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_rise
      assign rise[i] = level[i] & ~last[i];
    end
  endgenerate

endmodule : scan_edge_detect

// file: verification/scan_trigger_asserts.sv
// Port checker for the scan trigger controller, bound to its top module.
`timescale 1ns/10ps
module scan_trigger_checker
  import scan_trigger_pkg::*;
(
  // Clock, reset and watched inputs.
  input wire logic clk,
  input wire logic reset,
  input wire logic ext_input,
  input wire logic ext_is_start,
  input wire logic decode_ok,
  input wire logic verify_en,
  input wire logic linked_ctrl,
  // Watched outputs.
  input wire logic acquiring,
  input wire logic result_valid,
  input wire logic result_good,
  input wire logic result_fail_char_valid,
  input wire logic [7:0] result_char,
  input wire logic led_orange,
  input wire logic led_green,
  input wire logic led_red,
  input wire op_mode_t mode
);
  // All checks share the one clock and are off during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // A failed read reports the fixed fail character.
  fail_char_a:
    assert property (result_valid && !result_good && !verify_en
      |-> result_fail_char_valid && result_char == FAIL_CHAR) else $error("Bad fail char.");
  // A result comes only as acquisition ends, once.
  stop_once_a:
    assert property (result_valid |-> $fell(acquiring) ##1 !result_valid) else $error("Bad stop.");
  // Start lights orange and clears the result lamps.
  start_leds_a:
    assert property ($rose(acquiring) && linked_ctrl |-> led_orange && !led_green && !led_red)
      else $error("Bad start lamps.");
  // Stop drops orange and shows the verdict.
  result_leds_a:
    assert property (result_valid && linked_ctrl |-> !led_orange && led_green == result_good
      && led_red == !result_good) else $error("Bad result lamps.");
  // A decode during acquisition ends it with success next cycle.
  success_stop_a:
    assert property (acquiring && decode_ok && !verify_en |=> result_valid && result_good)
      else $error("Missed success.");
  // A qualified external rise while idle starts acquisition one cycle on.
  ext_start_a:
    assert property ($rose(ext_input) && ext_is_start && !acquiring && mode == MODE_SLAVE
      |=> acquiring) else $error("Missed start.");
  // Entering slave mode darkens every status lamp.
  slave_dark_a:
    assert property ($changed(mode) && mode == MODE_SLAVE |-> !led_orange && !led_green
      && !led_red) else $error("Lamps lit in slave entry.");
  // Acquisition never starts outside slave mode.
  slave_only_a:
    assert property (mode != MODE_SLAVE |-> !$rose(acquiring)) else $error("Start off slave.");
endmodule : scan_trigger_checker

bind scan_trigger_controller scan_trigger_checker checker_i (.clk, .reset, .ext_input,
  .ext_is_start, .decode_ok, .verify_en, .linked_ctrl, .acquiring, .result_valid, .result_good,
  .result_fail_char_valid, .result_char, .led_orange, .led_green, .led_red, .mode);

// file: verification/host_trigger.sv
// Host model that drives the external trigger input.
`timescale 1ns/10ps
module host_trigger (
  // Clock.
  input wire logic clk,
  // Commands from the bench: hold the input on for hold cycles.
  input wire logic fire,
  input wire logic [7:0] hold,
  // Lines to the scanner.
  output logic ext_input,
  output logic ext_is_start
);
  logic [7:0] left = 8'h00;
  // Counts down the on time; only this one source is used per request.
  always_ff @(posedge clk) begin
    if (fire) begin
      left <= hold;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // Input function is start-reading before any trigger.
  assign ext_is_start = 1'b1;
  assign ext_input = (left != 8'h00);
endmodule : host_trigger

// file: verification/scan_trigger_controller_tb.sv
// Self-checking bench for the scan trigger controller.
`timescale 1ns/10ps
module scan_trigger_controller_tb
  import scan_trigger_pkg::*;
();
  logic clk = 1'b0, reset = 1'b1, button = 1'b0, cmd_start = 1'b0, cmd_stop = 1'b0;
  logic cmd_mode_valid = 1'b0, decode_ok = 1'b0, fire = 1'b0, saw_rev = 1'b0;
  logic button_mode = 1'b0, cmd_save = 1'b0, verify_en = 1'b0;
  logic acquiring, result_valid, result_good, result_fail_char_valid, led_orange, led_green;
  logic led_red, settings_revert, ext_input, ext_is_start;
  logic [7:0] hold = 8'h00;
  logic [7:0] result_char;
  logic [TIMEOUT_W-1:0] timeout_ms = 15'h0005;
  op_mode_t cmd_mode = MODE_SLAVE;
  op_mode_t mode;
  int error_cnt = 0, n_checks = 0, n, n0;

  // Clock with a 100 ns period.
  always #50 clk = ~clk;
  // Remembers any revert pulse.
  always @(posedge clk) if (settings_revert === 1'b1) saw_rev <= 1'b1;

  // Design with shortened counts, and the host model.
  scan_trigger_controller #(.ILLUM_TIME_CYCLES(20), .BUTTON_TIME_CYCLES(30), .TICKS_PER_MS(2))
  uut (.clk, .reset, .button, .cmd_start, .cmd_stop, .ext_input, .ext_is_start, .cmd_mode_valid,
    .cmd_mode, .button_mode, .cmd_save, .timeout_ms, .linked_ctrl(1'b1),
    .verify_en, .decode_ok, .verify_match(1'b0), .acquiring, .result_valid, .result_good,
    .result_fail_char_valid, .result_char, .led_orange, .led_green, .led_red, .mode,
    .settings_revert);
  host_trigger host (.clk, .fire, .hold, .ext_input, .ext_is_start);

  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task conclude;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // Verdict flags: good, fail char, red, green.
  task res(input logic [7:0] e);
    check({4'h0, result_good, result_fail_char_valid, led_red, led_green}, e);
  endtask : res

  task ext_pulse(input logic [7:0] h);
    @(posedge clk) hold <= h;
    fire <= 1'b1;
    @(posedge clk) fire <= 1'b0;
  endtask : ext_pulse

  task wait_acq;
    for (int i = 0; i < 8 && acquiring !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check({7'h00, acquiring}, 8'h01);
  endtask : wait_acq

  // Waits for the result and counts cycles still acquiring.
  task wait_stop(output int cnt);
    cnt = 0;
    for (int i = 0; i < 60 && result_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      cnt += (acquiring === 1'b1);
    end
    check({7'h00, result_valid}, 8'h01);
  endtask : wait_stop

  // Finite timeout without decode, twice: same length, red verdict, no refire.
  task edge_timeout;
    for (int k = 0; k < 2; k++) begin
      ext_pulse(8'h28);
      wait_acq();
      check({7'h00, led_orange}, 8'h01);
      wait_stop(n);
      if (k == 0) n0 = n;
      check(8'(n), 8'(n0));
      check(8'(n >= 9 && n <= 11), 8'h01);
      res(8'h06);
      check(result_char, 8'h3F);
      repeat (5) @(posedge clk);
      #1;
      check({7'h00, acquiring}, 8'h00);
      repeat (30) @(posedge clk);
      #1;
      check({7'h00, led_red}, 8'h00);
    end
  endtask : edge_timeout

  // Decode success ends an edge request: green verdict, then red on a verification mismatch.
  task edge_success;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) verify_en <= (k == 1);
      ext_pulse(8'h28);
      wait_acq();
      @(posedge clk) decode_ok <= 1'b1;
      @(posedge clk) decode_ok <= 1'b0;
      #1;
      wait_stop(n);
      res((k == 0) ? 8'h09 : 8'h02);
      check({7'h00, led_orange}, 8'h00);
      repeat (40) @(posedge clk);
    end
    verify_en <= 1'b0;
  endtask : edge_success

  // Infinite timeout: reads while the input stays on; button is ignored.
  task level_mode;
    @(posedge clk) timeout_ms <= TIMEOUT_INFINITE;
    ext_pulse(8'h1E);
    wait_acq();
    wait_stop(n);
    check(8'(n > 20), 8'h01);
    res(8'h06);
    // A success while the input stays on ends the read and does not restart it.
    ext_pulse(8'h1E);
    wait_acq();
    @(posedge clk) decode_ok <= 1'b1;
    @(posedge clk) decode_ok <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({7'h00, acquiring}, 8'h00);
    repeat (25) @(posedge clk);
    @(posedge clk) button <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({7'h00, acquiring}, 8'h00);
    @(posedge clk) button <= 1'b0;
  endtask : level_mode

  // Command start and stop, then a button read with its fixed timeout.
  task other_sources;
    @(posedge clk) timeout_ms <= 15'h0005;
    cmd_start <= 1'b1;
    @(posedge clk) cmd_start <= 1'b0;
    wait_acq();
    @(posedge clk) cmd_stop <= 1'b1;
    @(posedge clk) cmd_stop <= 1'b0;
    #1;
    wait_stop(n);
    check(8'(n <= 3), 8'h01);
    @(posedge clk) button <= 1'b1;
    wait_acq();
    wait_stop(n);
    check(8'(n >= 29 && n <= 31), 8'h01);
    @(posedge clk) button <= 1'b0;
  endtask : other_sources

  // Unsaved change then mode switches by command; slave entry darkens lamps.
  task mode_change;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) timeout_ms <= 15'h0007;
      cmd_mode <= (k == 0) ? MODE_SETUP : MODE_SLAVE;
      cmd_mode_valid <= 1'b1;
      @(posedge clk) cmd_mode_valid <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(8'(mode), (k == 0) ? 8'h01 : 8'h00);
    end
    check({7'h00, saw_rev}, 8'h01);
    res(8'h00);
  endtask : mode_change

  // Reset with the button held gives setup mode; a saved change then survives a button switch.
  task power_up;
    @(posedge clk) reset <= 1'b1;
    button <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(8'(mode), 8'h01);
    @(posedge clk) button <= 1'b0;
    timeout_ms <= 15'h0009;
    cmd_save <= 1'b1;
    @(posedge clk) cmd_save <= 1'b0;
    button_mode <= 1'b1;
    @(posedge clk) button_mode <= 1'b0;
    #1;
    check({7'h00, settings_revert}, 8'h00);
    check(8'(mode), 8'h00);
  endtask : power_up

  // Main sequence after a four-cycle reset.
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(8'(mode), 8'h00);
    edge_timeout();
    edge_success();
    level_mode();
    other_sources();
    mode_change();
    power_up();
    conclude();
  end

  // Watchdog well beyond the expected run of about 330 cycles.
  initial begin
    #500000;
    error_cnt++;
    conclude();
  end
endmodule : scan_trigger_controller_tb
